// File: src/sarseq_top.sv
// Successive-approximation conversion sequencer top
`default_nettype none
module sarseq_top #(
  parameter int WIDTH = sarseq_pkg::RES_BITS
) (
  input wire logic CLOCK_IN, // System clock, 125 MHz
  input wire logic RST_N_IN, // Async reset, active low
  input wire logic OSC_IN, // Converter oscillator pin
  input wire logic SEL_N_IN, // Device select, active low
  input wire logic RD_N_IN, // Read strobe, active low
  input wire logic UPPER_BYTE_SELECT_IN, // High blocks start
  input wire logic COMP_IN, // Comparator decision, 1 keeps trial bit
  output logic OSC_OUT, // Inverted oscillator copy
  output logic BUSY_N_OUT, // Low while converting
  output logic [WIDTH-1:0] TRIAL_OUT, // Trial word to DAC
  output logic [WIDTH-1:0] DATA_OUT, // Result latch
  output logic [WIDTH-1:0] DATA_OE_OUT // Data driver enables
);
  sarseq_pkg::sarseq_ctl_s ctl_w;
  sarseq_pkg::sarseq_ctl_s ctl_sync_w;
  logic [1:0] osc_sync_w;
  logic osc_s;
  logic comp_s;
  logic osc_d_r;
  sarseq_pkg::sarseq_state_e state_r, state_nxt;
  logic [WIDTH-1:0] trial_r, trial_nxt;
  logic [WIDTH-1:0] result_r, result_nxt;
  logic [$clog2(WIDTH)-1:0] idx_r, idx_nxt;
  logic busy_n_r, busy_n_nxt;
  logic osc_out_r;
  logic oe_r;
  logic [WIDTH-1:0] oe_w;
  logic start_w;
  logic osc_fall_w;
  logic osc_edge_w;
  logic read_w;
  logic last_w;

  assign ctl_w = '{sel_n: SEL_N_IN, rd_n: RD_N_IN, upper_byte_select: UPPER_BYTE_SELECT_IN};

  sarseq_sync #(.WIDTH(3)) u_ctl_sync (
    .clk_in(CLOCK_IN),
    .rst_n_in(RST_N_IN),
    .d_in(ctl_w),
    .rst_val_in(3'h7),
    .q_out(ctl_sync_w)
  );

  sarseq_sync #(.WIDTH(2)) u_osc_sync (
    .clk_in(CLOCK_IN),
    .rst_n_in(RST_N_IN),
    .d_in({OSC_IN, COMP_IN}),
    .rst_val_in(2'h3),
    .q_out(osc_sync_w)
  );

  assign osc_s = osc_sync_w[1];
  assign comp_s = osc_sync_w[0];

  assign start_w = !ctl_sync_w.sel_n && !ctl_sync_w.rd_n && !ctl_sync_w.upper_byte_select;
  assign read_w = !ctl_sync_w.sel_n && !ctl_sync_w.rd_n;
  assign osc_fall_w = osc_d_r && !osc_s;
  // one bit per falling edge, 12 to 13 periods in all
  assign osc_edge_w = osc_fall_w;
  assign last_w = (idx_r == '0);

  always_comb begin
    state_nxt = state_r;
    trial_nxt = trial_r;
    result_nxt = result_r;
    idx_nxt = idx_r;
    busy_n_nxt = busy_n_r;
    case (state_r)
      sarseq_pkg::SARSEQ_IDLE: begin
        if (start_w) begin
          trial_nxt = sarseq_pkg::TRIAL_RST;
          idx_nxt = sarseq_pkg::MSB_INDEX;
          busy_n_nxt = 1'b0;
          state_nxt = sarseq_pkg::SARSEQ_WAIT_FALL;
        end
      end
      sarseq_pkg::SARSEQ_WAIT_FALL: begin
        if (osc_fall_w) begin
          trial_nxt[idx_r] = 1'b1;
          state_nxt = sarseq_pkg::SARSEQ_TRIAL;
        end
      end
      sarseq_pkg::SARSEQ_TRIAL: begin
        // decide MSB first, one bit per edge
        if (osc_edge_w) begin
          trial_nxt[idx_r] = comp_s;
          if (last_w) begin
            state_nxt = sarseq_pkg::SARSEQ_LOAD;
          end else begin
            idx_nxt = idx_r - 1'b1;
            trial_nxt[idx_r - 1'b1] = 1'b1;
          end
        end
      end
      sarseq_pkg::SARSEQ_LOAD: begin
        result_nxt = trial_r;
        state_nxt = sarseq_pkg::SARSEQ_IDLE;
      end
      default: state_nxt = sarseq_pkg::SARSEQ_IDLE;
    endcase
    // busy rises on the same edge as the latch load
    if (state_r == sarseq_pkg::SARSEQ_LOAD) begin
      busy_n_nxt = 1'b1;
    end
  end

  // drivers on while read strobe holds
  assign oe_w = {WIDTH{read_w}};

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_r <= sarseq_pkg::SARSEQ_IDLE;
      trial_r <= sarseq_pkg::TRIAL_RST;
      result_r <= sarseq_pkg::RESULT_RST;
      idx_r <= '0;
      busy_n_r <= 1'b1;
      osc_d_r <= 1'b1;
      osc_out_r <= 1'b0;
      oe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      trial_r <= trial_nxt;
      result_r <= result_nxt;
      idx_r <= idx_nxt;
      busy_n_r <= busy_n_nxt;
      osc_d_r <= osc_s;
      osc_out_r <= !osc_s;
      oe_r <= read_w;
    end
  end

  assign OSC_OUT = osc_out_r;
  assign BUSY_N_OUT = busy_n_r;
  assign TRIAL_OUT = trial_r;
  assign DATA_OUT = result_r;
  assign DATA_OE_OUT = {WIDTH{oe_r}};

  // Assertions
  a_busy_on_start: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (state_r == sarseq_pkg::SARSEQ_IDLE && start_w) |=> !BUSY_N_OUT)
    else $error("busy not asserted on start");
  a_no_restart: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (state_r == sarseq_pkg::SARSEQ_TRIAL) |=> state_r != sarseq_pkg::SARSEQ_WAIT_FALL)
    else $error("conversion restarted");
  a_upper_blocks: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (state_r == sarseq_pkg::SARSEQ_IDLE && ctl_sync_w.upper_byte_select)
    |=> BUSY_N_OUT)
    else $error("start with upper byte select high");
  a_trial_cleared: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (state_r == sarseq_pkg::SARSEQ_IDLE && start_w) |=> TRIAL_OUT == '0)
    else $error("trial not cleared");
  a_load_result: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (state_r == sarseq_pkg::SARSEQ_LOAD) |=> DATA_OUT == $past(TRIAL_OUT))
    else $error("result not loaded");
  a_busy_after_load: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    $rose(BUSY_N_OUT) |-> $past(state_r) == sarseq_pkg::SARSEQ_LOAD)
    else $error("busy rose early");
  a_result_hold: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (state_r != sarseq_pkg::SARSEQ_LOAD) |=> $stable(DATA_OUT))
    else $error("result changed mid-conversion");
  a_osc_invert: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    $changed(osc_s) |=> OSC_OUT == !$past(osc_s))
    else $error("oscillator copy not inverted");
  a_msb_first: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (state_r == sarseq_pkg::SARSEQ_WAIT_FALL && osc_fall_w)
    |=> TRIAL_OUT[WIDTH-1])
    else $error("msb not tried first");

  // Helper count of falls since start, checked at the latch load
  logic [4:0] fall_cnt_r;
  logic [4:0] fall_cnt_nxt;

  assign fall_cnt_nxt = (state_r == sarseq_pkg::SARSEQ_IDLE) ? 5'h00
    : (osc_fall_w ? fall_cnt_r + 5'h01 : fall_cnt_r);

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      fall_cnt_r <= 5'h00;
    end else begin
      fall_cnt_r <= fall_cnt_nxt;
    end
  end

  // Start taken in idle
  sequence s_start_taken;
    state_r == sarseq_pkg::SARSEQ_IDLE && start_w;
  endsequence

  // Busy low with the trial word cleared
  sequence s_run_begun;
    !BUSY_N_OUT && TRIAL_OUT == '0 && state_r == sarseq_pkg::SARSEQ_WAIT_FALL;
  endsequence

  // First falling oscillator edge after start
  sequence s_first_fall;
    state_r == sarseq_pkg::SARSEQ_WAIT_FALL && osc_fall_w;
  endsequence

  // MSB under trial, waiting for its deciding fall
  sequence s_msb_armed;
    state_r == sarseq_pkg::SARSEQ_TRIAL && idx_r == sarseq_pkg::MSB_INDEX
      && TRIAL_OUT[WIDTH-1];
  endsequence

  // Last bit decided on this fall
  sequence s_last_decision;
    state_r == sarseq_pkg::SARSEQ_TRIAL && last_w && osc_fall_w;
  endsequence

  a_start_arms: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    s_start_taken |=> s_run_begun)
    else $error("start did not arm the run");

  a_msb_armed: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    s_first_fall |=> s_msb_armed)
    else $error("msb not armed at first fall");

  a_msb_decided: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (s_msb_armed ##0 osc_fall_w) |=> TRIAL_OUT[WIDTH-1] == $past(comp_s))
    else $error("msb decision wrong");

  // nothing moves before the first fall
  a_wait_fall: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (state_r == sarseq_pkg::SARSEQ_WAIT_FALL && !osc_fall_w)
    |=> state_r == sarseq_pkg::SARSEQ_WAIT_FALL && TRIAL_OUT == '0)
    else $error("sequence began before first fall");

  // each fall but the last steps one bit down
  a_step_one_bit: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (state_r == sarseq_pkg::SARSEQ_TRIAL && osc_fall_w && !last_w)
    |=> (idx_r + 1'b1) == $past(idx_r) && TRIAL_OUT[idx_r])
    else $error("bit step wrong");

  a_hold_between: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (state_r == sarseq_pkg::SARSEQ_TRIAL && !osc_fall_w)
    |=> $stable(idx_r) && $stable(TRIAL_OUT))
    else $error("bit stepped without a fall");

  // held strobes do not disturb a run
  a_run_ignores: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (state_r == sarseq_pkg::SARSEQ_TRIAL && start_w && !osc_fall_w)
    |=> $stable(TRIAL_OUT))
    else $error("start disturbed a running conversion");

  // load, then busy released with new data
  a_last_loads: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    s_last_decision |=> (state_r == sarseq_pkg::SARSEQ_LOAD && !BUSY_N_OUT)
    ##1 (BUSY_N_OUT && DATA_OUT == $past(TRIAL_OUT)))
    else $error("end of conversion out of order");

  // thirteen falls from start to load
  a_fall_total: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (state_r == sarseq_pkg::SARSEQ_LOAD) |-> fall_cnt_r == sarseq_pkg::CONV_FALLS)
    else $error("conversion length wrong");

  // busy low in every running state
  a_busy_held: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (state_r != sarseq_pkg::SARSEQ_IDLE) |-> !BUSY_N_OUT)
    else $error("busy high during conversion");

  // idle stays idle without a full start
  a_idle_needs_start: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    (state_r == sarseq_pkg::SARSEQ_IDLE && !start_w)
    |=> state_r == sarseq_pkg::SARSEQ_IDLE && BUSY_N_OUT)
    else $error("conversion without start");

  a_drivers_on: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    read_w |=> DATA_OE_OUT == '1)
    else $error("drivers not enabled");

  a_drivers_off: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    !read_w |=> DATA_OE_OUT == '0)
    else $error("drivers left enabled");

  // copy steady while the input is
  a_osc_steady: assert property (@(posedge CLOCK_IN) disable iff (!RST_N_IN)
    !$changed(osc_s) |=> OSC_OUT == !$past(osc_s))
    else $error("oscillator copy drifted");
endmodule
`default_nettype wire

// File: src/sarseq_pkg.sv
// Shared constants and carrier types of the conversion sequencer
// What this block does
// - Conversion starts only from select, read and upper byte select inputs.
// - On start, clear the bit-trial register and enable data drivers.
// - Start conditions are ignored while a conversion runs.
// - Bit-trial register drives a 12-bit trial word, MSB first to LSB.
// - MSB decision follows the second falling oscillator edge after start.
// - Each remaining bit is resolved on a following edge, one per edge.
// - At end, the full trial word is copied into a 12-bit result latch.
// - Unaligned read strobe gives 12 to 13 oscillator periods of conversion.
// - Sequence waits for first falling oscillator edge after start.
// - Oscillator output pin shows the inverted oscillator input.
// - Result is straight binary, one step equals full scale over 4096.
// - Start needs select, read and upper byte select all low together.
// - Upper byte select high blocks any conversion start.
// - Active-low busy stays low for the whole conversion.
// - Busy rises on the same clock edge that updates the result latch.
`default_nettype none
package sarseq_pkg;
  localparam int RES_BITS = 12;
  localparam logic [11:0] RESULT_RST = 12'h000;
  localparam logic [11:0] TRIAL_RST = 12'h000;
  localparam logic [3:0] MSB_INDEX = 4'hB;
  localparam int SYNC_STAGES = 2;
  // One arming fall plus one deciding fall per bit
  localparam logic [4:0] CONV_FALLS = 5'h0D;

  typedef struct packed {
    logic sel_n;
    logic rd_n;
    logic upper_byte_select;
  } sarseq_ctl_s;

  typedef enum logic [1:0] {
    SARSEQ_IDLE,
    SARSEQ_WAIT_FALL,
    SARSEQ_TRIAL,
    SARSEQ_LOAD
  } sarseq_state_e;
endpackage
`default_nettype wire

// File: src/sarseq_sync.sv
// Two-stage synchroniser for asynchronous level inputs
`default_nettype none
module sarseq_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in, // Clock
  input wire logic rst_n_in, // Async reset, active low
  input wire logic [WIDTH-1:0] d_in, // Async levels
  input wire logic [WIDTH-1:0] rst_val_in, // Unused constant pattern source
  output logic [WIDTH-1:0] q_out // Synchronised levels
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] unused_w;

  assign unused_w = rst_val_in;
  assign q_out = q_r;

  // Inactive pattern is all ones for active-low strobes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_r <= '1;
      q_r <= '1;
    end else begin
      meta_r <= d_in;
      q_r <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: sim/sarseq_far_model.sv
// Oscillator and comparator standing beside the sequencer
`default_nettype none
module sarseq_far_model #(
  parameter int HALF = 5
) (
  input wire logic clk_in, // Bench clock
  input wire logic [11:0] trial_in, // Trial word from the sequencer
  input wire logic [11:0] target_in, // Analog level as a code
  output logic osc_out, // Oscillator level
  output logic comp_out // 1 keeps the trial bit
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  initial osc_out = 1'b1;
  always @(posedge clk_in) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      osc_out <= ~osc_out;
    end
  end
  assign comp_out = (trial_in <= target_in);
endmodule
`default_nettype wire

// File: sim/sar_conversion_sequencer_bench.sv
// Self-checking bench for the conversion sequencer
`default_nettype none
module sar_conversion_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HALF = 5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel_n = 1'b1;
  logic rd_n = 1'b1;
  logic upper = 1'b0;
  logic osc, comp, osc_q, busy_n;
  logic [11:0] trial, data, oe;
  logic [11:0] target = 12'h000;
  logic [11:0] vals [5] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'hA5C};
  int fails = 0;
  int check_count = 0;
  always #4 clk = ~clk;
  sarseq_top u_dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .OSC_IN(osc), .SEL_N_IN(sel_n),
    .RD_N_IN(rd_n), .UPPER_BYTE_SELECT_IN(upper), .COMP_IN(comp), .OSC_OUT(osc_q),
    .BUSY_N_OUT(busy_n), .TRIAL_OUT(trial), .DATA_OUT(data), .DATA_OE_OUT(oe));
  sarseq_far_model #(.HALF(HALF)) u_far (.clk_in(clk), .trial_in(trial),
    .target_in(target), .osc_out(osc), .comp_out(comp));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic strobe(input logic s, input logic r, input logic u);
    @(posedge clk);
    sel_n <= s;
    rd_n <= r;
    upper <= u;
  endtask
  // Bounded wait, sampled on the falling edge away from updates
  task automatic wait_busy(input logic lvl, output int n);
    n = 0;
    while (busy_n !== lvl && n < 400) begin
      @(negedge clk);
      n++;
    end
    check({11'h000, busy_n}, {11'h000, lvl});
  endtask
  task automatic convert(input logic [11:0] val, input logic [11:0] prev, input bit again);
    int n;
    target <= val;
    strobe(1'b0, 1'b0, 1'b0);
    wait_busy(1'b0, n);
    @(negedge clk);
    check(oe, 12'hFFF);
    check(data, prev);
    strobe(1'b1, 1'b1, 1'b0);
    if (again) begin
      // Second start mid-run must be ignored
      repeat (10) @(posedge clk);
      strobe(1'b0, 1'b0, 1'b0);
      repeat (3) @(posedge clk);
      strobe(1'b1, 1'b1, 1'b0);
    end
    wait_busy(1'b1, n);
    if (!again) check({11'h000, n >= 24 * HALF - 4 && n <= 26 * HALF + 4}, 12'h001);
    check(data, val);
    repeat (30) @(negedge clk);
    check({11'h000, busy_n}, 12'h001);
  endtask
  task automatic blocked_starts;
    int lows;
    for (int k = 0; k < 3; k++) begin
      lows = 0;
      strobe(k == 1, k == 2, k == 0);
      repeat (30) begin
        @(negedge clk);
        lows += (busy_n !== 1'b1);
      end
      check(12'(lows), 12'h000);
      strobe(1'b1, 1'b1, 1'b0);
    end
  endtask
  task automatic osc_copy;
    repeat (4) begin
      @(osc);
      repeat (4) @(negedge clk);
      check({11'h000, osc_q}, {11'h000, ~osc});
    end
  endtask
  initial begin
    #200000;
    fails++;
    summarize();
  end
  initial begin
    logic [11:0] prev;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(negedge clk);
    check({11'h000, busy_n}, 12'h001);
    prev = sarseq_pkg::RESULT_RST;
    osc_copy();
    blocked_starts();
    for (int i = 0; i < 5; i++) begin
      // last start aligned to a rising oscillator edge
      if (i == 4) @(posedge osc);
      convert(vals[i], prev, 1'b0);
      prev = vals[i];
    end
    convert(12'h3C5, prev, 1'b1);
    summarize();
  end
endmodule
`default_nettype wire
